// ===== nibble_io_pkg.sv
// Constants and types shared by the nibble I/O port design files.
// Assumes a single 250 MHz system clock and a synchronous active-low reset.
package nibble_io_pkg;

  // ---------------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned PORT_W      = 4;
  localparam logic [3:0]  DIR_RST     = 4'h0;  // All pins input after reset.
  localparam logic [3:0]  OUT_RST     = 4'h0;
  localparam logic        PULL_EN_RST = 1'b1;  // Pull-low enabled after reset.
  localparam int unsigned SYNC_STAGES = 2;

  typedef logic [PORT_W-1:0] nibble_t;

  typedef enum logic [0:0] {
    ST_RUN,
    ST_SLEEP
  } power_t;

endpackage : nibble_io_pkg

// ===== nibble_io_port.sv
// Top of the nibble I/O port with power-down wake.
// Holds the output latch, the direction and pull-low settings, the power state
// and the edge detector that ends power-down.
// Assumes the controller drives its strobes on I_CLK and pad logic resolves pins.
// Assumes the pins are asynchronous and pass the two-flop bank before any use.
`timescale 1ns/1ps

module nibble_io_port
  import nibble_io_pkg::*;
(
  input  wire logic                    I_CLK,
  input  wire logic                    I_RSTN,
  input  wire logic                    I_WR_DATA,     // Write output nibble.
  input  wire nibble_io_pkg::nibble_t  I_DATA,
  input  wire logic                    I_WR_DIR,      // Write direction nibble.
  input  wire nibble_io_pkg::nibble_t  I_DIR,         // 1 = output.
  input  wire logic                    I_WR_PULL,     // Write pull-low enable.
  input  wire logic                    I_PULL_EN,
  input  wire logic                    I_END,         // End instruction pulse.
  input  wire nibble_io_pkg::nibble_t  I_PINS,        // Pad input levels.
  output nibble_io_pkg::nibble_t       O_PINS,        // Pad output levels.
  output nibble_io_pkg::nibble_t       O_PINS_OE,     // High while driving.
  output nibble_io_pkg::nibble_t       O_PULL_LOW,    // Weak N-MOS gate per pin.
  output nibble_io_pkg::nibble_t       O_RD_DATA,     // Port read value.
  output logic                         O_POWER_DOWN,
  output logic                         O_WAKE         // One-cycle wake pulse.
);

  // ---------------------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------------------
  nibble_t      pins_s;
  nibble_t      pins_prev_q;
  nibble_t      out_q;
  nibble_t      dir_q;
  logic         pull_q;
  power_t       pwr_q;
  power_t       pwr_d;
  wire          edge_any;
  wire          in_sleep;
  wire          sleep_d;
  wire nibble_t rd_d;
  wire nibble_t pull_d;

  nibble_io_sync u_sync (
    .i_clk   (I_CLK),
    .i_rst_n (I_RSTN),
    .i_async (I_PINS),
    .o_sync  (pins_s)
  );

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  // Sleep is decoded for the present and the next state alike.
  function automatic logic is_asleep(input power_t st);
    return (st == ST_SLEEP);
  endfunction

  // An edge is a change between two synchronised samples on any pin.
  assign edge_any = |(pins_s ^ pins_prev_q);
  assign in_sleep = is_asleep(pwr_q);
  assign sleep_d  = is_asleep(pwr_d);

  // Per-pin selection; each pin looks only at its own direction bit.
  for (genvar g = 0; g < PORT_W; g++) begin : g_pin
    // Output pins read back their latch; inputs read the pad.
    assign rd_d[g]   = dir_q[g] ? out_q[g] : pins_s[g];
    // Pull-low only acts on inputs, so an output never fights its own device.
    assign pull_d[g] = pull_q & ~dir_q[g];
  end

  // Limitation: edges are found on synchronised samples, so a pin pulse
  // shorter than one clock period may be missed and never wake the chip.
  // An end instruction while already asleep is ignored rather than queued.
  // Power state: end enters sleep, an edge leaves it.
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      ST_RUN:   if (I_END) pwr_d = ST_SLEEP;
      ST_SLEEP: if (edge_any) pwr_d = ST_RUN;
      default:  pwr_d = ST_RUN;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  // Each written nibble replaces the whole field; per-pin direction is a bit.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      out_q  <= OUT_RST;
      dir_q  <= DIR_RST;
      pull_q <= PULL_EN_RST;
    end else begin
      if (I_WR_DATA) out_q <= I_DATA;
      if (I_WR_DIR)  dir_q <= I_DIR;
      if (I_WR_PULL) pull_q <= I_PULL_EN;
    end
  end

  // ---------------------------------------------------------------------------
  // Power state and edge history
  // ---------------------------------------------------------------------------
  // Edge history runs in every state so the sleep detector never misses one.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      pwr_q       <= ST_RUN;
      pins_prev_q <= '0;
    end else begin
      pwr_q       <= pwr_d;
      pins_prev_q <= pins_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------------
  // Every output is a flop, so pad timing never depends on the decode above;
  // the price is one more cycle from a strobe to the pins.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_PINS       <= OUT_RST;
      O_PINS_OE    <= DIR_RST;
      O_PULL_LOW   <= {PORT_W{PULL_EN_RST}};
      O_RD_DATA    <= '0;
      O_POWER_DOWN <= 1'b0;
      O_WAKE       <= 1'b0;
    end else begin
      O_PINS       <= out_q;
      O_PINS_OE    <= dir_q;
      O_PULL_LOW   <= pull_d;
      O_RD_DATA    <= rd_d;
      O_POWER_DOWN <= sleep_d;
      O_WAKE       <= in_sleep & edge_any;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  // Checks sample on every rising clock edge and stand idle while reset is held.
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  chk_reset_inputs: assert property (
    $rose(I_RSTN) |-> (O_PINS_OE == 4'h0) && (O_PULL_LOW == 4'hf))
    else $error("Pins not inputs with pull-low after reset.");

  chk_dir_write: assert property (
    I_WR_DIR |-> ##2 (O_PINS_OE == $past(I_DIR, 2)))
    else $error("Direction write not reflected two cycles later.");

  chk_data_write: assert property (
    I_WR_DATA |-> ##2 (O_PINS == $past(I_DATA, 2)))
    else $error("Data write not driven two cycles later.");

  chk_pull_off: assert property (
    (I_WR_PULL && !I_PULL_EN && !I_WR_DIR) |-> ##2 (O_PULL_LOW == 4'h0))
    else $error("Pull-low still on after disable.");

  chk_pull_output: assert property (
    (O_PULL_LOW & O_PINS_OE) == 4'h0)
    else $error("Pull-low active on a driven pin.");

  chk_end_sleep: assert property (
    (I_END && !in_sleep) |-> ##1 O_POWER_DOWN)
    else $error("End did not enter power-down.");

  chk_edge_wake: assert property (
    (in_sleep && edge_any) |-> ##1 (O_WAKE && !O_POWER_DOWN))
    else $error("Edge in power-down did not wake.");

  chk_sleep_hold: assert property (
    (in_sleep && !edge_any) |-> ##1 O_POWER_DOWN)
    else $error("Left power-down without an edge.");

  chk_wake_single: assert property (
    O_WAKE |-> ##1 !O_WAKE)
    else $error("Wake pulse lasted more than one cycle.");

  chk_wake_awake: assert property (
    O_WAKE |-> !O_POWER_DOWN)
    else $error("Wake pulse while still in power-down.");

  chk_wake_cause: assert property (
    O_WAKE |-> $past(in_sleep && edge_any))
    else $error("Wake pulse without an edge in power-down.");

  chk_out_hold: assert property (
    !I_WR_DATA |-> ##2 $stable(O_PINS))
    else $error("Output nibble changed without a write.");

  chk_dir_hold: assert property (
    !I_WR_DIR |-> ##2 $stable(O_PINS_OE))
    else $error("Direction changed without a write.");

  chk_pull_hold: assert property (
    (!I_WR_PULL && !I_WR_DIR) |-> ##2 $stable(O_PULL_LOW))
    else $error("Pull-low changed without a write.");

  chk_rd_latch: assert property (
    (I_WR_DATA && I_WR_DIR) |-> ##2
      ((O_RD_DATA & $past(I_DIR, 2)) == ($past(I_DATA, 2) & $past(I_DIR, 2))))
    else $error("Output pins did not read back their latch.");

  chk_pull_inputs: assert property (
    (I_WR_PULL && I_PULL_EN && I_WR_DIR) |-> ##2 (O_PULL_LOW == ~$past(I_DIR, 2)))
    else $error("Pull-low not on exactly the input pins.");

  // Covers: a sleep and wake, a redundant end, pull-off, mixed pins, floating input.
  cov_sleep_wake: cover property (I_END ##[1:20] O_WAKE);
  cov_end_asleep: cover property (in_sleep && I_END);
  cov_pull_off:   cover property (I_WR_PULL && !I_PULL_EN);
  cov_mixed_dir:  cover property (O_PINS_OE == 4'h5);
  cov_float_in:   cover property (!O_PULL_LOW[0] && !O_PINS_OE[0] && $changed(O_RD_DATA[0]));

endmodule // nibble_io_port

// ===== nibble_io_sync.sv
// Two-flop synchroniser bank for the port pin inputs.
// Assumes the pins are asynchronous to I_CLK; only stage two is read outside.
`timescale 1ns/1ps

module nibble_io_sync
  import nibble_io_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  input  wire nibble_io_pkg::nibble_t  i_async,
  output nibble_io_pkg::nibble_t       o_sync
);

  // ---------------------------------------------------------------------------
  // Synchroniser stages
  // ---------------------------------------------------------------------------
  nibble_t meta_q;

  // Stage one feeds stage two only, to keep metastability contained.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule // nibble_io_sync

// ===== pin_world.sv
// Model of the keys and loads that sit on the four port pins.
// Assumes the port outputs are registered on the same clock.
`timescale 1ns/1ps

module pin_world
  import nibble_io_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire nibble_io_pkg::nibble_t  i_drv,
  input  wire nibble_io_pkg::nibble_t  i_oe,
  input  wire nibble_io_pkg::nibble_t  i_pull,
  input  wire nibble_io_pkg::nibble_t  i_key_en,
  input  wire nibble_io_pkg::nibble_t  i_key_val,
  output nibble_io_pkg::nibble_t       o_pins
);
  nibble_t float_q = 4'h5;

  // A floating pin wanders, so it flips every cycle rather than hold a value.
  always @(posedge i_clk) begin
    float_q <= ~float_q;
  end

  // Port drive wins, then a key, then the weak pull-low to ground.
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      o_pins[i] = i_oe[i] ? i_drv[i] : i_key_en[i] ? i_key_val[i] :
                  i_pull[i] ? 1'b0 : float_q[i];
    end
  end
endmodule // pin_world

// ===== test_nibble_io_port.sv
// Self-checking bench for the nibble I/O port with power-down wake.
// Assumes the pin_world model resolves the pad levels.
`timescale 1ns/1ps

module test_nibble_io_port;
  import nibble_io_pkg::*;
  logic    clk, rstn = 0, wr_data = 0, wr_dir = 0, wr_pull = 0, pull_en = 1, end_cmd = 0;
  nibble_t data = 4'h0, dir = 4'h0, key_en = 4'h0, key_val = 4'h0;
  nibble_t pins, drv, oe, pull, rd;
  logic    pd, wake;
  int      n_errors = 0, total_checks = 0, cycles = 0;

  nibble_io_port u_dut (.I_CLK(clk), .I_RSTN(rstn), .I_WR_DATA(wr_data), .I_DATA(data),
    .I_WR_DIR(wr_dir), .I_DIR(dir), .I_WR_PULL(wr_pull), .I_PULL_EN(pull_en),
    .I_END(end_cmd), .I_PINS(pins), .O_PINS(drv), .O_PINS_OE(oe), .O_PULL_LOW(pull),
    .O_RD_DATA(rd), .O_POWER_DOWN(pd), .O_WAKE(wake));
  pin_world u_world (.i_clk(clk), .i_drv(drv), .i_oe(oe), .i_pull(pull),
    .i_key_en(key_en), .i_key_val(key_val), .o_pins(pins));

  // Clock of 4 ns, and a cycle ceiling that cuts a hang short.
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      final_report();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string what, nibble_t exp, nibble_t got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // All three strobes together; outputs settle two edges later, pad reads three more.
  task automatic cfg(nibble_t d, nibble_t r, logic p);
    @(posedge clk);
    {wr_data, wr_dir, wr_pull} <= 3'h7;
    data <= d;
    dir <= r;
    pull_en <= p;
    @(posedge clk);
    {wr_data, wr_dir, wr_pull} <= 3'h0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic pulse_end();
    @(posedge clk);
    end_cmd <= 1'b1;
    @(posedge clk);
    end_cmd <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("oe", 4'h0, oe);
    chk("pull", 4'hf, pull);
    chk("pd", 4'h0, {3'h0, pd});
    chk("drv", 4'h0, drv);
    chk("wake", 4'h0, {3'h0, wake});
    $display("test reset done");
  endtask

  // Outputs on pins 0 and 2, then pin 1 joins without disturbing the rest.
  task automatic t_dir();
    cfg(4'hf, 4'h5, 1'b1);
    chk("oe", 4'h5, oe);
    chk("drv", 4'h5, drv & oe);
    chk("drv", 4'hf, drv);
    chk("pull", 4'ha, pull);
    chk("rd", 4'h5, rd);
    cfg(4'hf, 4'h7, 1'b1);
    chk("oe", 4'h7, oe);
    chk("rd", 4'h7, rd);
    $display("test direction done");
  endtask

  // A reset in mid-run puts every driven pin back to input with pull-low.
  task automatic t_rereset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk("oe", 4'h0, oe);
    chk("pull", 4'hf, pull);
    chk("drv", 4'h0, drv);
    $display("test mid-run reset done");
  endtask

  // With pull-lows off an unloaded input floats, so its read value wanders.
  task automatic t_pull();
    nibble_t r0;
    cfg(4'h0, 4'h0, 1'b0);
    chk("pull", 4'h0, pull);
    chk("drv", 4'h0, drv);
    r0 = rd;
    @(posedge clk);
    #1;
    chk("rd float", ~r0, rd);
    key_en <= 4'h8;
    key_val <= 4'h8;
    cfg(4'h0, 4'h0, 1'b1);
    chk("rd", 4'h8, rd);
    key_en <= 4'h0;
    repeat (4) @(posedge clk);
    #1;
    chk("rd", 4'h0, rd);
    $display("test pull done");
  endtask

  // Every pin wakes the chip on a rising and on a falling edge.
  task automatic t_wake();
    logic woke;
    key_en <= 4'hf;
    for (int k = 0; k < 8; k++) begin
      pulse_end();
      pulse_end();
      chk("pd", 4'h1, {3'h0, pd});
      key_val[k % 4] <= ~key_val[k % 4];
      woke = 0;
      for (int n = 0; n < 8 && !woke; n++) begin
        @(posedge clk);
        #1;
        woke = (wake === 1'b1);
      end
      chk("wake", 4'h1, {3'h0, woke});
      chk("pd", 4'h0, {3'h0, pd});
    end
    $display("test wake done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_dir();
    t_rereset();
    t_pull();
    t_wake();
    final_report();
  end
endmodule // test_nibble_io_port
